// [hdl/insa_pkg.sv]
// constants for the nonvolatile store command handler
// assumes a byte-level i2c slave front end supplies decoded phases
package insa_pkg;
    localparam logic [7:0] CMD_ADDR = 8'h10;
    localparam logic [7:0] CMD_WRITE = 8'h12;
    localparam logic [7:0] CMD_READ = 8'h14;
    localparam logic [9:0] USER2_LO = 10'h080;
    localparam logic [9:0] USER2_HI = 10'h3FF;
    localparam logic [9:0] CFGW_LO = 10'h050;
    localparam logic [9:0] CFGW_HI = 10'h07E;
    localparam logic [9:0] RSVD_LO = 10'h040;
    localparam logic [9:0] RSVD_HI = 10'h04E;
    localparam logic [9:0] USER1_LO = 10'h012;
    localparam logic [9:0] USER1_HI = 10'h03E;
    localparam logic [9:0] CFGL_LO = 10'h000;
    localparam logic [9:0] CFGL_HI = 10'h010;
    localparam int WORDS = 1024;
    localparam int PROG_CYCLES = 16;
    localparam int READ_CYCLES = 2;
    localparam logic [7:0] CSUM_SEED = 8'h00;
    typedef enum logic [1:0] {
        INSA_IDLE = 2'b00,
        INSA_PROG = 2'b01,
        INSA_READ = 2'b10
    } insa_store_t;
    typedef enum logic [1:0] {
        INSA_WAIT_CMD = 2'b00,
        INSA_ADDR_HI = 2'b01,
        INSA_ADDR_LO = 2'b10,
        INSA_DATA = 2'b11
    } insa_phase_t;
endpackage

// [hdl/insa_store.sv]
// nonvolatile store array with checksum over configuration regions
// assumes one request at a time; busy held until completion
`timescale 1ns/1ps
module insa_store (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // request
    input wire logic wr_req_in,
    input wire logic rd_req_in,
    input wire logic [9:0] word_in,
    input wire logic byte_sel_in,
    input wire logic [7:0] wdata_in,
    // answer
    output logic busy_out,
    output logic done_out,
    output logic [7:0] rdata_out,
    output logic [7:0] csum_out
);
    logic [15:0] mem [insa_pkg::WORDS];
    logic [15:0] word_sel;
    insa_pkg::insa_store_t state;
    logic [4:0] cnt;
    logic [9:0] wa;
    logic ws;
    logic [7:0] wd;

    assign busy_out = (state != insa_pkg::INSA_IDLE);
    assign word_sel = mem[wa];

    function automatic logic in_cfg(input logic [9:0] a);
        in_cfg = (a >= insa_pkg::CFGW_LO && a <= insa_pkg::CFGW_HI) ||
            (a <= insa_pkg::CFGL_HI);
    endfunction

    // busy from start until the operation completes
    always_ff @(posedge clock_in) begin
        done_out <= 1'b0;
        if (!nrst_in) begin
            state <= insa_pkg::INSA_IDLE;
            cnt <= 5'h00;
            wa <= 10'h000;
            ws <= 1'b0;
            wd <= 8'h00;
            rdata_out <= 8'h00;
        end else begin
            unique case (state)
                insa_pkg::INSA_IDLE: begin
                    wa <= word_in;
                    ws <= byte_sel_in;
                    wd <= wdata_in;
                    if (wr_req_in) begin
                        state <= insa_pkg::INSA_PROG;
                        cnt <= 5'(insa_pkg::PROG_CYCLES - 1);
                    end else if (rd_req_in) begin
                        state <= insa_pkg::INSA_READ;
                        cnt <= 5'(insa_pkg::READ_CYCLES - 1);
                    end
                end
                insa_pkg::INSA_PROG, insa_pkg::INSA_READ: begin
                    cnt <= cnt - 5'h01;
                    if (cnt == 5'h00) begin
                        state <= insa_pkg::INSA_IDLE;
                        done_out <= 1'b1;
                        if (state == insa_pkg::INSA_READ) begin
                            rdata_out <= ws ? word_sel[15:8] : word_sel[7:0];
                        end
                    end
                end
                default: state <= insa_pkg::INSA_IDLE;
            endcase
        end
    end

    // blank array at power-on, write at end of programming
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < insa_pkg::WORDS; i++) begin
                mem[i] <= 16'h0000;
            end
        end else if (state == insa_pkg::INSA_PROG && cnt == 5'h00) begin
            if (ws) begin
                mem[wa][15:8] <= wd;
            end else begin
                mem[wa][7:0] <= wd;
            end
        end
    end

    // byte sum over writable configuration words
    logic [7:0] sum;
    always_comb begin
        sum = insa_pkg::CSUM_SEED;
        for (int i = 0; i < insa_pkg::WORDS; i++) begin
            if (in_cfg(10'(i))) begin
                sum = sum + mem[i][7:0] + mem[i][15:8];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            csum_out <= 8'h00;
        end else begin
            csum_out <= sum;
        end
    end
endmodule // insa_store

// [hdl/insa_top.sv]
// command handler for i2c access to the nonvolatile store
// assumes an i2c byte engine: it reports general-call command and data
// bytes, asks for an ack decision, and requests a byte to send
`timescale 1ns/1ps
module insa_top (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // byte engine, received bytes
    input wire logic start_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    input wire logic stop_in,
    // byte engine, read data request
    input wire logic rd_byte_req_in,
    // ack decision and read data
    output logic ack_valid_out,
    output logic ack_out,
    output logic tx_valid_out,
    output logic tx_ack_out,
    output logic [7:0] tx_data_out,
    // status
    output logic busy_out,
    output logic [15:0] addr_out,
    output logic write_refused_out,
    output logic [7:0] csum_out
);
    insa_pkg::insa_phase_t phase;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] addr_hi;
    logic cmd_acked;
    logic wr_req;
    logic rd_req;
    logic [7:0] wdata;
    logic st_busy;
    logic st_done;
    logic [7:0] st_rdata;
    logic [7:0] st_csum;
    logic read_ready;
    logic [7:0] read_byte;
    logic [9:0] word;
    logic reserved;
    logic busy_now;

    // byte address to word and byte lane
    assign word = addr[10:1];
    assign reserved = (word >= insa_pkg::RSVD_LO) &&
        (word <= insa_pkg::RSVD_HI);
    assign busy_now = st_busy | wr_req | rd_req;

    insa_store u_store (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .wr_req_in(wr_req),
        .rd_req_in(rd_req),
        .word_in(word),
        .byte_sel_in(addr[0]),
        .wdata_in(wdata),
        .busy_out(st_busy),
        .done_out(st_done),
        .rdata_out(st_rdata),
        .csum_out(st_csum)
    );

    // command phase tracking and ack decisions
    always_ff @(posedge clock_in) begin
        ack_valid_out <= 1'b0;
        if (!nrst_in || start_in || stop_in) begin
            phase <= insa_pkg::INSA_WAIT_CMD;
            cmd <= 8'h00;
            cmd_acked <= 1'b0;
            ack_out <= 1'b0;
        end else if (byte_valid_in) begin
            ack_valid_out <= 1'b1;
            unique case (phase)
                insa_pkg::INSA_WAIT_CMD: begin
                    cmd <= byte_in;
                    // ack shows idle store
                    cmd_acked <= !busy_now;
                    ack_out <= !busy_now &&
                        (byte_in == insa_pkg::CMD_ADDR ||
                        byte_in == insa_pkg::CMD_WRITE ||
                        byte_in == insa_pkg::CMD_READ);
                    if (byte_in == insa_pkg::CMD_ADDR) begin
                        phase <= insa_pkg::INSA_ADDR_HI;
                    end else if (byte_in == insa_pkg::CMD_WRITE) begin
                        phase <= insa_pkg::INSA_DATA;
                    end
                end
                insa_pkg::INSA_ADDR_HI: begin
                    ack_out <= !busy_now;
                    phase <= insa_pkg::INSA_ADDR_LO;
                end
                insa_pkg::INSA_ADDR_LO: begin
                    ack_out <= !busy_now;
                    phase <= insa_pkg::INSA_WAIT_CMD;
                end
                insa_pkg::INSA_DATA: begin
                    ack_out <= !busy_now && cmd_acked;
                    phase <= insa_pkg::INSA_WAIT_CMD;
                end
            endcase
        end
    end

    // address register loads only while idle
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            addr <= 16'h0000;
            addr_hi <= 8'h00;
        end else if (byte_valid_in && !start_in && !stop_in && !busy_now)
        begin
            if (phase == insa_pkg::INSA_ADDR_HI) begin
                addr_hi <= byte_in;
            end else if (phase == insa_pkg::INSA_ADDR_LO) begin
                addr <= {addr_hi, byte_in};
            end
        end
    end

    // write starts only with both phases acked
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            wr_req <= 1'b0;
            wdata <= 8'h00;
            write_refused_out <= 1'b0;
        end else begin
            wr_req <= 1'b0;
            if (byte_valid_in && !start_in && !stop_in &&
                phase == insa_pkg::INSA_DATA && cmd_acked && !busy_now) begin
                wdata <= byte_in;
                // reserved region stays unchanged
                wr_req <= !reserved;
                write_refused_out <= reserved;
            end
        end
    end

    // read start on acked read command
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rd_req <= 1'b0;
            read_ready <= 1'b0;
            read_byte <= 8'h00;
        end else begin
            rd_req <= byte_valid_in && !start_in && !stop_in &&
                phase == insa_pkg::INSA_WAIT_CMD &&
                byte_in == insa_pkg::CMD_READ && !busy_now;
            if (rd_req) begin
                read_ready <= 1'b0;
            end else if (st_done && !st_busy) begin
                read_ready <= 1'b1;
                read_byte <= st_rdata;
            end
        end
    end

    // read data answer: ack while idle once a read or a write has completed
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            tx_valid_out <= 1'b0;
            tx_ack_out <= 1'b0;
            tx_data_out <= 8'h00;
        end else begin
            tx_valid_out <= rd_byte_req_in;
            if (rd_byte_req_in) begin
                tx_ack_out <= read_ready && !busy_now;
                tx_data_out <= read_byte;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            busy_out <= 1'b0;
            addr_out <= 16'h0000;
            csum_out <= 8'h00;
        end else begin
            busy_out <= busy_now;
            addr_out <= addr;
            csum_out <= st_csum;
        end
    end
endmodule // insa_top

// [verification/insa_top_monitor.sv]
// checker for the nonvolatile store command handler
// assumes it is bound to insa_top; all ports watched are the top's ports
`timescale 1ns/1ps
module insa_top_monitor (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // byte engine side
    input wire logic start_in,
    input wire logic byte_valid_in,
    input wire logic stop_in,
    input wire logic rd_byte_req_in,
    input wire logic [7:0] byte_in,
    // answers and status
    input wire logic ack_valid_out,
    input wire logic ack_out,
    input wire logic tx_valid_out,
    input wire logic tx_ack_out,
    input wire logic busy_out,
    input wire logic write_refused_out,
    input wire logic [7:0] tx_data_out,
    input wire logic [7:0] csum_out,
    input wire logic [15:0] addr_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_ack_follows_byte: assert property (
        byte_valid_in && !start_in && !stop_in |=> ack_valid_out)
        else $error("no ack decision after byte");
    a_busy_gives_nak: assert property (
        (byte_valid_in && !start_in && !stop_in) ##1 busy_out |-> !ack_out)
        else $error("byte acked while store busy");
    // address port trails its acked byte by one cycle
    a_addr_load_acked: assert property (
        $changed(addr_out) |-> $past(ack_valid_out) && $past(ack_out))
        else $error("address changed without acked byte");
    a_tx_follows_req: assert property (
        rd_byte_req_in |=> tx_valid_out)
        else $error("no answer to read byte request");
    a_tx_nak_busy: assert property (
        tx_valid_out && busy_out |-> !tx_ack_out)
        else $error("read data acked while busy");
    a_busy_min_hold: assert property (
        $rose(busy_out) |-> busy_out [*2])
        else $error("busy dropped too early");
    // checksum port trails the array write by two cycles
    a_csum_only_busy: assert property (
        $changed(csum_out) |-> $past(busy_out, 2))
        else $error("checksum moved with store idle");
    a_refused_has_cause: assert property (
        $rose(write_refused_out) |->
        $past(byte_valid_in) || $past(byte_valid_in, 2))
        else $error("refusal without received byte");
    cover property (ack_valid_out && !ack_out);
    cover property ($rose(busy_out));
    cover property (tx_valid_out && tx_ack_out);
    cover property ($rose(write_refused_out));
endmodule // insa_top_monitor

// [verification/insa_master.sv]
// i2c master byte engine model facing the command handler
// assumes it drives at falling edges and answers come one cycle later
`timescale 1ns/1ps
module insa_master (
    // clock and answers
    input wire logic clock_in,
    input wire logic ack_in, tx_ack_in,
    input wire logic [7:0] tx_data_in,
    // frame and byte drive
    output logic start_out, byte_valid_out, stop_out, rd_req_out,
    output logic [7:0] byte_out
);
    // idle levels on all drive lines
    task automatic idle();
        start_out = 1'b0;
        byte_valid_out = 1'b0;
        stop_out = 1'b0;
        rd_req_out = 1'b0;
        byte_out = 8'h00;
    endtask
    // start or stop condition pulse
    task automatic cond(input logic is_stop);
        @(negedge clock_in);
        start_out = !is_stop;
        stop_out = is_stop;
        @(negedge clock_in);
        start_out = 1'b0;
        stop_out = 1'b0;
    endtask
    // one general-call byte, returns ack
    task automatic put(input logic [7:0] b, output logic a);
        @(negedge clock_in);
        byte_valid_out = 1'b1;
        byte_out = b;
        @(negedge clock_in);
        byte_valid_out = 1'b0;
        byte_out = ~b;
        a = ack_in;
    endtask
    // one read data phase; caller retries on nak
    task automatic get(output logic a, output logic [7:0] d);
        @(negedge clock_in);
        rd_req_out = 1'b1;
        @(negedge clock_in);
        rd_req_out = 1'b0;
        a = tx_ack_in;
        d = tx_data_in;
    endtask
endmodule // insa_master

// [verification/insa_top_tb.sv]
// testbench for the nonvolatile store command handler
// assumes insa_top, insa_master and the monitor are compiled before it
`timescale 1ns/1ps
module insa_top_tb;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic start, byte_valid, stop, rd_req, ack_valid, ack, tx_valid, tx_ack;
    logic busy, refused;
    logic [7:0] byte_v, tx_data, csum;
    logic [15:0] addr;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2.5 clock_in = ~clock_in;
    insa_top dut (.clock_in(clock_in), .nrst_in(nrst_in), .start_in(start),
        .byte_valid_in(byte_valid), .byte_in(byte_v), .stop_in(stop),
        .rd_byte_req_in(rd_req), .ack_valid_out(ack_valid), .ack_out(ack),
        .tx_valid_out(tx_valid), .tx_ack_out(tx_ack), .tx_data_out(tx_data),
        .busy_out(busy), .addr_out(addr), .write_refused_out(refused),
        .csum_out(csum));
    insa_master master (.clock_in(clock_in), .ack_in(ack), .tx_ack_in(tx_ack),
        .tx_data_in(tx_data), .start_out(start), .byte_valid_out(byte_valid),
        .stop_out(stop), .rd_req_out(rd_req), .byte_out(byte_v));
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic set_addr(input logic [15:0] a, input logic ok);
        logic k0, k1, k2;
        master.cond(1'b0);
        master.put(insa_pkg::CMD_ADDR, k0);
        master.put(a[15:8], k1);
        master.put(a[7:0], k2);
        master.cond(1'b1);
        check("addr ack", 16'({k0, k1, k2}), 16'({3{ok}}));
    endtask
    task automatic write_byte(input logic [7:0] d, input logic ok);
        logic k0, k1;
        master.cond(1'b0);
        master.put(insa_pkg::CMD_WRITE, k0);
        master.put(d, k1);
        master.cond(1'b1);
        check("write ack", 16'({k0, k1}), 16'({2{ok}}));
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(negedge clock_in);
        while (busy === 1'b1 && n < 200) begin
            @(negedge clock_in);
            n++;
        end
        check("idle", 16'(busy), 16'h0000);
    endtask
    task automatic read_byte(output logic [7:0] d);
        logic k, a;
        int n;
        n = 0;
        a = 1'b0;
        master.cond(1'b0);
        master.put(insa_pkg::CMD_READ, k);
        check("read cmd ack", 16'(k), 16'h0001);
        while (a !== 1'b1 && n < 20) begin
            master.get(a, d);
            n++;
        end
        master.cond(1'b1);
        check("read data ack", 16'(a), 16'h0001);
    endtask
    // write then read back, user words only
    task automatic t_user(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        set_addr(a, 1'b1);
        check("addr", addr, a);
        write_byte(d, 1'b1);
        check("refused", 16'(refused), 16'h0000);
        wait_idle();
        read_byte(r);
        check("readback", 16'(r), 16'(d));
    endtask
    task automatic t_reserved(input logic [15:0] a);
        logic [7:0] r0, r1;
        set_addr(a, 1'b1);
        read_byte(r0);
        write_byte(~r0, 1'b1);
        check("refused", 16'(refused), 16'h0001);
        wait_idle();
        read_byte(r1);
        check("reserved kept", 16'(r1), 16'(r0));
    endtask
    task automatic t_csum(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r0, c0;
        set_addr(a, 1'b1);
        read_byte(r0);
        c0 = csum;
        write_byte(d, 1'b1);
        wait_idle();
        // checksum port trails busy by one cycle
        repeat (2) @(negedge clock_in);
        check("csum", 16'(csum), 16'(8'(c0 - r0 + d)));
    endtask
    // commands sent while programming are refused
    task automatic t_busy();
        logic k;
        int n;
        n = 0;
        set_addr(16'h0102, 1'b1);
        write_byte(8'h11, 1'b1);
        while (busy !== 1'b1 && n < 10) begin
            @(negedge clock_in);
            n++;
        end
        master.cond(1'b0);
        master.put(insa_pkg::CMD_READ, k);
        master.cond(1'b1);
        check("read while busy", 16'(k), 16'h0000);
        set_addr(16'h0200, 1'b0);
        check("addr kept", addr, 16'h0102);
        wait_idle();
    endtask
    task automatic t_bad_cmd();
        logic k;
        master.cond(1'b0);
        master.put(8'h16, k);
        master.cond(1'b1);
        check("unknown cmd ack", 16'(k), 16'h0000);
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        master.idle();
        repeat (20) @(negedge clock_in);
        nrst_in = 1'b1;
        check("reset addr", addr, 16'h0000);
        check("reset csum", 16'(csum), 16'h0000);
        t_user(16'h0100, 8'hA5);
        t_user(16'h07FF, 8'h3C);
        t_user(16'h0024, 8'h5A);
        t_user(16'h007D, 8'hC3);
        t_reserved(16'h0080);
        t_reserved(16'h009D);
        t_csum(16'h00A0, 8'h07);
        t_csum(16'h0021, 8'h5A);
        t_busy();
        t_bad_cmd();
        test_done();
    end
endmodule // insa_top_tb
bind insa_top insa_top_monitor mon (.clock_in(clock_in), .nrst_in(nrst_in),
    .start_in(start_in), .byte_valid_in(byte_valid_in), .stop_in(stop_in),
    .rd_byte_req_in(rd_byte_req_in), .byte_in(byte_in),
    .ack_valid_out(ack_valid_out), .ack_out(ack_out),
    .tx_valid_out(tx_valid_out), .tx_ack_out(tx_ack_out),
    .busy_out(busy_out), .write_refused_out(write_refused_out),
    .tx_data_out(tx_data_out), .csum_out(csum_out), .addr_out(addr_out));
